//--- core/crs_pkg.sv
package crs_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFS_GPR_BASE   = 8'h00;
  localparam logic [7:0] OFS_MAIN_SP    = 8'h40;
  localparam logic [7:0] OFS_PROC_SP    = 8'h44;
  localparam logic [7:0] OFS_STATUS     = 8'h48;
  localparam logic [7:0] OFS_FLAGS      = 8'h4c;
  localparam logic [7:0] OFS_EXCNUM     = 8'h50;
  localparam logic [7:0] OFS_EXEC       = 8'h54;
  localparam logic [7:0] OFS_EXC_MASK   = 8'h58;
  localparam logic [7:0] OFS_FLTMASK_R  = 8'h5c;
  localparam logic [7:0] OFS_THRESH     = 8'h60;
  localparam logic [7:0] OFS_MODE       = 8'h64;
  localparam logic [7:0] OFS_CORE_STATE = 8'h68;

  // ==========================================================
  // register indices and field layout
  localparam int IDX_SP      = 13;
  localparam int IDX_LINK    = 14;
  localparam int IDX_PC      = 15;
  localparam int FLAGS_LSB   = 27;
  localparam int EXCNUM_MSB  = 8;
  localparam int ISTATE_BIT  = 24;
  localparam int MODE_USER   = 0;
  localparam int MODE_ALTSP  = 1;
  localparam int THRESH_W    = 9;

  localparam logic [31:0] FLAGS_MASK  = 32'hf800_0000;
  localparam logic [31:0] EXCNUM_MASK = 32'h0000_01ff;
  localparam logic [31:0] EXEC_MASK   = 32'h0600_fc00;
  localparam logic [31:0] ISTATE_MASK = 32'h0100_0000;
  localparam logic [31:0] SP_ALIGN    = 32'hffff_fffc;
  localparam logic [31:0] PC_ALIGN    = 32'hffff_fffe;

  // ==========================================================
  // reset values
  localparam logic [31:0]         RST_STATUS = 32'h0100_0000;
  localparam logic [THRESH_W-1:0] RST_THRESH = 9'h000;
  localparam logic [1:0]          RST_MODE   = 2'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // pipeline write port
  typedef struct packed {
    logic        en;
    logic [3:0]  idx;
    logic        wide;
    logic [31:0] data;
  } crs_gpr_wr_t;

  typedef struct packed {
    logic        en;
    logic [31:0] ret;
  } crs_call_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RESP = 2'b01
  } crs_bus_st_t;

endpackage

//--- core/crs_core.sv
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module crs_core (
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST_N,
  input  wire logic [7:0]            S_AXI_AWADDR,
  input  wire logic                  S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  input  wire logic [31:0]           S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  input  wire logic                  S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  output logic [1:0]                 S_AXI_BRESP,
  output logic                       S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  input  wire logic [7:0]            S_AXI_ARADDR,
  input  wire logic                  S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  output logic [31:0]                S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  output logic                       S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY,
  input  wire crs_pkg::crs_gpr_wr_t  GPR_WR,
  input  wire crs_pkg::crs_call_t    CALL,
  input  wire logic [3:0]            RD_IDX,
  input  wire logic                  RD_WIDE,
  output logic [31:0]                RD_DATA,
  output logic                       RD_DENIED,
  input  wire logic                  EXC_ENTER,
  input  wire logic [8:0]            EXC_NUM,
  input  wire logic                  EXC_RETURN,
  input  wire logic                  FLAGS_WE,
  input  wire logic [4:0]            FLAGS_IN,
  input  wire logic                  IRQ_REQ,
  input  wire logic [8:0]            IRQ_PRIO,
  input  wire logic                  IRQ_IS_NMI,
  input  wire logic                  IRQ_IS_HARDFAULT,
  output logic                       IRQ_TAKE_OK,
  output logic                       USER_LEVEL,
  output logic                       HANDLER_MODE,
  output logic                       FAULT
);
  import crs_pkg::*;

  // ==========================================================
  // storage
  logic [31:0]         gpr [0:15];
  logic [31:0]         main_stack_ptr;
  logic [31:0]         process_stack_ptr;
  logic [31:0]         program_status;
  logic                exception_mask_primary;
  logic                fault_level_mask;
  logic [THRESH_W-1:0] priority_mask_threshold;
  logic [1:0]          operating_mode_select;
  logic                handler;
  crs_bus_st_t         wr_st;
  crs_bus_st_t         rd_st;
  logic                aw_got;
  logic                w_got;
  logic [7:0]          aw_addr;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;

  // ==========================================================
  // mode and stack selection
  logic        user_now;
  logic        use_proc_sp;
  logic [31:0] stack_ptr;

  assign user_now = !handler && operating_mode_select[MODE_USER];
  assign use_proc_sp = !handler && user_now
                       && operating_mode_select[MODE_ALTSP];
  assign stack_ptr = (use_proc_sp ? process_stack_ptr : main_stack_ptr)
                     & SP_ALIGN;

  // ==========================================================
  // bus write decode
  logic        bus_do_wr;
  logic [31:0] bw;
  logic        bus_ok_wr;

  assign bus_do_wr = aw_got && w_got && wr_st == ST_IDLE;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      bw[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : 8'h00;
    end
  end
  assign bus_ok_wr = aw_addr <= OFS_CORE_STATE && aw_addr[1:0] == 2'h0;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // general purpose, link and program counter
  logic gpr_wr_ok;
  assign gpr_wr_ok = GPR_WR.en && (GPR_WR.idx < 4'h8
                     || GPR_WR.wide);

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_gpr
      if (gi != IDX_SP) begin : g_reg
        always_ff @(posedge SYS_CLK) begin
          if (!RST_N) begin
            gpr[gi] <= 32'h0;
          end else if (gi == IDX_LINK && CALL.en) begin
            gpr[gi] <= CALL.ret;
          end else if (gpr_wr_ok && GPR_WR.idx == 4'(gi)) begin
            gpr[gi] <= (gi == IDX_PC) ? (GPR_WR.data & PC_ALIGN)
                                      : GPR_WR.data;
          end else if (bus_do_wr && bus_ok_wr
                       && aw_addr == OFS_GPR_BASE + 8'(gi * 4)) begin
            gpr[gi] <= (gi == IDX_PC)
                       ? (merge(gpr[gi], bw, w_strb) & PC_ALIGN)
                       : merge(gpr[gi], bw, w_strb);
          end
        end
      end else begin : g_sp
        assign gpr[gi] = stack_ptr;
      end
    end
  endgenerate

  // ==========================================================
  // banked stack pointers
  logic sp_pipe_wr;
  assign sp_pipe_wr = gpr_wr_ok && GPR_WR.idx == 4'(IDX_SP);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      main_stack_ptr <= 32'h0;
    end else if (sp_pipe_wr && !use_proc_sp) begin
      main_stack_ptr <= GPR_WR.data & SP_ALIGN;
    end else if (bus_do_wr && aw_addr == OFS_MAIN_SP) begin
      main_stack_ptr <= merge(main_stack_ptr, bw, w_strb) & SP_ALIGN;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      process_stack_ptr <= 32'h0;
    end else if (sp_pipe_wr && use_proc_sp) begin
      process_stack_ptr <= GPR_WR.data & SP_ALIGN;
    end else if (bus_do_wr && aw_addr == OFS_PROC_SP) begin
      process_stack_ptr <= merge(process_stack_ptr, bw, w_strb)
                           & SP_ALIGN;
    end
  end

  // ==========================================================
  // program status views
  logic        st_wr;
  logic [31:0] st_mask;
  logic [31:0] st_val;
  logic        istate_clear;

  always_comb begin
    st_wr   = bus_do_wr && !user_now;
    st_mask = 32'h0;
    unique case (aw_addr)
      OFS_STATUS: st_mask = FLAGS_MASK | EXCNUM_MASK | EXEC_MASK;
      OFS_FLAGS:  st_mask = FLAGS_MASK;
      OFS_EXCNUM: st_mask = EXCNUM_MASK;
      OFS_EXEC:   st_mask = EXEC_MASK | ISTATE_MASK;
      default:    st_wr = 1'b0;
    endcase
  end
  assign st_val = merge(program_status, bw, w_strb);
  assign istate_clear = st_wr && (aw_addr == OFS_STATUS
                        || aw_addr == OFS_EXEC)
                        && w_strb[3] && !bw[ISTATE_BIT];

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      program_status <= RST_STATUS;
    end else begin
      if (st_wr && !istate_clear) begin
        program_status <= ((program_status & ~st_mask)
                           | (st_val & st_mask))
                          | ISTATE_MASK;
      end
      if (FLAGS_WE) begin
        program_status[31:FLAGS_LSB] <= FLAGS_IN;
      end
      if (EXC_ENTER) begin
        program_status[EXCNUM_MSB:0] <= EXC_NUM;
      end else if (EXC_RETURN) begin
        program_status[EXCNUM_MSB:0] <= 9'h000;
      end
    end
  end

  // ==========================================================
  // handler mode tracking
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      handler <= 1'b0;
    end else if (EXC_ENTER) begin
      handler <= 1'b1;
    end else if (EXC_RETURN) begin
      handler <= 1'b0;
    end
  end

  // ==========================================================
  // masks and mode control
  logic priv_wr;
  assign priv_wr = bus_do_wr && !user_now;
  logic [31:0] thr_merged;
  assign thr_merged = merge(32'(priority_mask_threshold), bw, w_strb);

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      exception_mask_primary  <= 1'b0;
      fault_level_mask        <= 1'b0;
      priority_mask_threshold <= RST_THRESH;
      operating_mode_select   <= RST_MODE;
    end else begin
      if (priv_wr && aw_addr == OFS_EXC_MASK && w_strb[0]) begin
        exception_mask_primary <= bw[0];
      end
      if (priv_wr && aw_addr == OFS_FLTMASK_R && w_strb[0]) begin
        fault_level_mask <= bw[0];
      end
      if (priv_wr && aw_addr == OFS_THRESH) begin
        priority_mask_threshold <= thr_merged[THRESH_W-1:0];
      end
      if (priv_wr && aw_addr == OFS_MODE && w_strb[0]) begin
        operating_mode_select <= {bw[MODE_ALTSP] && !handler,
                                  bw[MODE_USER]};
      end
      if (EXC_ENTER) begin
        operating_mode_select[MODE_ALTSP] <= 1'b0;
      end
    end
  end

  // ==========================================================
  // exception gating
  logic thresh_block;
  logic next_take_ok;
  assign thresh_block = priority_mask_threshold != RST_THRESH
                        && IRQ_PRIO >= priority_mask_threshold;
  always_comb begin
    if (!IRQ_REQ) begin
      next_take_ok = 1'b0;
    end else if (IRQ_IS_NMI) begin
      next_take_ok = 1'b1;
    end else if (fault_level_mask) begin
      next_take_ok = 1'b0;
    end else if (IRQ_IS_HARDFAULT) begin
      next_take_ok = 1'b1;
    end else begin
      next_take_ok = !exception_mask_primary && !thresh_block;
    end
  end

  // ==========================================================
  // pipeline read port and status outputs
  logic rd_denied;
  logic user_bus_wr;
  assign rd_denied = RD_IDX >= 4'h8 && RD_IDX <= 4'hc && !RD_WIDE;
  assign user_bus_wr = bus_do_wr && user_now
                       && aw_addr >= OFS_STATUS;

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      RD_DATA      <= 32'h0;
      RD_DENIED    <= 1'b0;
      IRQ_TAKE_OK  <= 1'b0;
      USER_LEVEL   <= 1'b0;
      HANDLER_MODE <= 1'b0;
      FAULT        <= 1'b0;
    end else begin
      RD_DATA      <= rd_denied ? 32'h0 : gpr[RD_IDX];
      RD_DENIED    <= rd_denied;
      IRQ_TAKE_OK  <= next_take_ok;
      USER_LEVEL   <= user_now;
      HANDLER_MODE <= handler;
      FAULT        <= istate_clear || user_bus_wr;
    end
  end

  // ==========================================================
  // axi4-lite write channel
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
      wr_st         <= ST_IDLE;
    end else begin
      S_AXI_AWREADY <= !aw_got && !S_AXI_AWREADY && wr_st == ST_IDLE;
      S_AXI_WREADY  <= !w_got && !S_AXI_WREADY && wr_st == ST_IDLE;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got  <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got  <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      unique case (wr_st)
        ST_IDLE: begin
          if (bus_do_wr) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (bus_ok_wr && !user_bus_wr
                             && !istate_clear) ? RESP_OKAY : RESP_SLVERR;
            wr_st        <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            wr_st        <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // axi4-lite read channel
  logic [31:0] rmux;
  logic        rok;
  always_comb begin
    rok  = 1'b1;
    rmux = 32'h0;
    if (S_AXI_ARADDR < OFS_MAIN_SP) begin
      rmux = gpr[S_AXI_ARADDR[5:2]];
    end else begin
      unique case (S_AXI_ARADDR)
        OFS_MAIN_SP:    rmux = main_stack_ptr;
        OFS_PROC_SP:    rmux = process_stack_ptr;
        OFS_STATUS:     rmux = program_status;
        OFS_FLAGS:      rmux = program_status & FLAGS_MASK;
        OFS_EXCNUM:     rmux = program_status & EXCNUM_MASK;
        OFS_EXEC:       rmux = program_status & (EXEC_MASK | ISTATE_MASK);
        OFS_EXC_MASK:   rmux = {31'h0, exception_mask_primary};
        OFS_FLTMASK_R:  rmux = {31'h0, fault_level_mask};
        OFS_THRESH:     rmux = {23'h0, priority_mask_threshold};
        OFS_MODE:       rmux = {30'h0, operating_mode_select};
        OFS_CORE_STATE: rmux = {30'h0, handler, user_now};
        default:        rok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= RESP_OKAY;
      rd_st         <= ST_IDLE;
    end else begin
      S_AXI_ARREADY <= rd_st == ST_IDLE && !S_AXI_ARREADY;
      unique case (rd_st)
        ST_IDLE: begin
          if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= rok ? rmux : 32'h0;
            S_AXI_RRESP   <= rok ? RESP_OKAY : RESP_SLVERR;
            S_AXI_ARREADY <= 1'b0;
            rd_st         <= ST_RESP;
          end
        end
        ST_RESP: begin
          if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            rd_st        <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  chk_istate_held: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    program_status[ISTATE_BIT]) else $error("state bit cleared");
  chk_sp_aligned: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    stack_ptr[1:0] == 2'h0) else $error("sp misaligned");
  chk_pc_aligned: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    !gpr[IDX_PC][0]) else $error("pc misaligned");
  chk_link_call: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    CALL.en |=> gpr[IDX_LINK] == $past(CALL.ret))
    else $error("link not written");
  chk_fault_nmi: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    IRQ_REQ && fault_level_mask && !IRQ_IS_NMI |=> !IRQ_TAKE_OK)
    else $error("fault mask leak");
  chk_prim_gate: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    IRQ_REQ && exception_mask_primary && !IRQ_IS_NMI
    && !IRQ_IS_HARDFAULT |=> !IRQ_TAKE_OK)
    else $error("primary mask leak");
  chk_thresh_zero: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    IRQ_REQ && priority_mask_threshold == 9'h0 && !exception_mask_primary
    && !fault_level_mask |=> IRQ_TAKE_OK)
    else $error("zero threshold blocked");
  chk_thresh_block: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    IRQ_REQ && !IRQ_IS_NMI && !IRQ_IS_HARDFAULT && thresh_block
    |=> !IRQ_TAKE_OK) else $error("threshold leak");
  chk_handler_msp: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    EXC_ENTER |=> !operating_mode_select[MODE_ALTSP] && handler)
    else $error("alt stack in handler");
  chk_handler_nostack: assert property (@(posedge SYS_CLK)
    disable iff (!RST_N) handler |-> !operating_mode_select[MODE_ALTSP])
    else $error("alt stack held in handler");
  chk_high_denied: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    RD_IDX == 4'h9 && !RD_WIDE |=> RD_DENIED)
    else $error("high reg narrow access");

endmodule

//--- tb/crs_pipe_model.sv
`timescale 1ns/1ps
module crs_pipe_model (
  input  wire logic          clk,
  output crs_pkg::crs_gpr_wr_t wr,
  output crs_pkg::crs_call_t   call,
  output logic               ent,
  output logic [8:0]         num,
  output logic               ret
);
  import crs_pkg::*;

  // ==========================================================
  // pipeline requests, one pulse each, payload scrambled after
  initial begin
    wr = '0;
    call = '0;
    ent = 1'b0;
    num = 9'h000;
    ret = 1'b0;
  end

  task automatic put(input logic [3:0] i, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    wr <= '{1'b1, i, w, d};
    @(posedge clk);
    wr <= '{1'b0, ~i, ~w, ~d};
  endtask

  task automatic link(input logic [31:0] d);
    @(posedge clk);
    call <= '{1'b1, d};
    @(posedge clk);
    call <= '{1'b0, ~d};
  endtask

  task automatic exc(input logic e, input logic [8:0] n);
    @(posedge clk);
    ent <= e;
    ret <= ~e;
    num <= n;
    @(posedge clk);
    ent <= 1'b0;
    ret <= 1'b0;
    num <= ~n;
  endtask
endmodule

//--- tb/crs_core_tb_top.sv
`timescale 1ns/1ps
module crs_core_tb_top;
  import crs_pkg::*;

  // ==========================================================
  // signals and model state
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic        awv = 1'b0, wv = 1'b0, bvr = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic [31:0] wd = 32'h0, rdat, rd_data, seed = 32'h0000_0050;
  logic [3:0]  rd_idx = 4'h0;
  logic [1:0]  bresp, rresp;
  logic        awr, wr_rdy, bv, arr, rv, rd_wide = 1'b0, rd_deny;
  logic        fwe = 1'b0, irq = 1'b0, nmi = 1'b0, hf = 1'b0;
  logic [4:0]  fin = 5'h00;
  logic [8:0]  prio = 9'h000, exc_num;
  logic        ok, user, hnd, fault, ent, ret;
  crs_gpr_wr_t gpr_wr;
  crs_call_t   call;
  int          num_errors = 0, comparisons = 0, faults = 0;
  int          m[16], prim, flt, thr;
  logic [31:0] main_sp, proc_sp, flags;
  logic [7:0]  rst_ofs[4] = '{OFS_EXC_MASK, OFS_FLTMASK_R, OFS_THRESH,
                              OFS_MODE};

  always #12.5 clk = ~clk;
  always @(posedge clk) if (fault === 1'h1) faults++;

  crs_core crs_core_i (
    .SYS_CLK(clk), .RST_N(rst_n),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bvr), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd), .GPR_WR(gpr_wr), .CALL(call),
    .RD_IDX(rd_idx), .RD_WIDE(rd_wide), .RD_DATA(rd_data),
    .RD_DENIED(rd_deny), .EXC_ENTER(ent), .EXC_NUM(exc_num),
    .EXC_RETURN(ret), .FLAGS_WE(fwe), .FLAGS_IN(fin), .IRQ_REQ(irq),
    .IRQ_PRIO(prio), .IRQ_IS_NMI(nmi), .IRQ_IS_HARDFAULT(hf),
    .IRQ_TAKE_OK(ok), .USER_LEVEL(user), .HANDLER_MODE(hnd),
    .FAULT(fault)
  );

  crs_pipe_model crs_pipe_model_i (
    .clk(clk), .wr(gpr_wr), .call(call), .ent(ent), .num(exc_num),
    .ret(ret)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bvr <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
      n++;
    end while (bv !== 1'b1 && n < 64);
    bvr <= 1'b0;
    chk("bvalid", 1'h1, bv);
    chk("bresp", er, bresp);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      n++;
    end while (rv !== 1'b1 && n < 64);
    rrd <= 1'b0;
    chk("rvalid", 1'h1, rv);
    chk("rresp", er, rresp);
    chk("rdata", e, rdat);
  endtask

  task automatic rdp(input logic [3:0] i, input logic w,
                     input logic [31:0] e);
    @(posedge clk);
    rd_idx <= i;
    rd_wide <= w;
    @(posedge clk);
    #1;
    chk("rd_data", e, rd_data);
    chk("rd_denied", !w && i >= 8 && i <= 12, rd_deny);
  endtask

  task automatic finish_test();
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // one pass of all scenarios
  task automatic run_pass();
    logic [31:0] d;
    logic [31:0] v;
    logic [8:0]  p;
    logic        x;
    int          nf;
    int          k;
    rdc(OFS_STATUS, RST_STATUS, RESP_OKAY);
    foreach (rst_ofs[i]) rdc(rst_ofs[i], 32'h0, RESP_OKAY);
    rdc(8'h6c, 32'h0, RESP_SLVERR);
    wrc(8'h70, rnd(), RESP_SLVERR);
    for (k = 0; k < 13; k++) begin
      d = rnd();
      crs_pipe_model_i.put(k[3:0], 1'b0, d);
      if (k < 8) m[k] = d;
      rdp(k[3:0], 1'b0, (k < 8) ? m[k] : 0);
      crs_pipe_model_i.put(k[3:0], 1'b1, ~d);
      m[k] = ~d;
      rdp(k[3:0], 1'b1, m[k]);
      rdc(OFS_GPR_BASE + 8'(4 * k), m[k], RESP_OKAY);
    end
    d = rnd();
    crs_pipe_model_i.put(4'hd, 1'b1, d);
    main_sp = d & SP_ALIGN;
    rdc(OFS_MAIN_SP, main_sp, RESP_OKAY);
    rdp(4'hd, 1'b1, main_sp);
    crs_pipe_model_i.put(4'hf, 1'b1, d);
    rdp(4'hf, 1'b1, d & PC_ALIGN);
    crs_pipe_model_i.link(~d);
    rdp(4'he, 1'b1, ~d);
    @(posedge clk);
    fwe <= 1'b1;
    fin <= d[4:0];
    @(posedge clk);
    fwe <= 1'b0;
    flags = {d[4:0], 27'h0};
    rdc(OFS_FLAGS, flags, RESP_OKAY);
    p = d[8:0] | 9'h010;
    crs_pipe_model_i.exc(1'b1, p);
    rdc(OFS_EXCNUM, 32'(p), RESP_OKAY);
    chk("handler", 1'h1, hnd);
    wrc(OFS_EXEC, EXEC_MASK | ISTATE_MASK, RESP_OKAY);
    v = flags | 32'(p) | EXEC_MASK | ISTATE_MASK;
    rdc(OFS_STATUS, v, RESP_OKAY);
    nf = faults;
    wrc(OFS_EXEC, 32'h0, RESP_SLVERR);
    rdc(OFS_STATUS, v, RESP_OKAY);
    chk("fault", nf + 1, faults);
    crs_pipe_model_i.exc(1'b0, 9'h000);
    rdc(OFS_EXCNUM, 32'h0, RESP_OKAY);
    wrc(OFS_MODE, 32'h3, RESP_OKAY);
    rdc(OFS_MODE, 32'h3, RESP_OKAY);
    chk("user", 1'h1, user);
    chk("handler", 1'h0, hnd);
    d = rnd();
    crs_pipe_model_i.put(4'hd, 1'b1, d);
    proc_sp = d & SP_ALIGN;
    rdc(OFS_PROC_SP, proc_sp, RESP_OKAY);
    rdc(OFS_MAIN_SP, main_sp, RESP_OKAY);
    nf = faults;
    wrc(OFS_THRESH, 32'h1, RESP_SLVERR);
    rdc(OFS_THRESH, 32'h0, RESP_OKAY);
    chk("fault", nf + 1, faults);
    crs_pipe_model_i.exc(1'b1, 9'h00f);
    rdc(OFS_MODE, 32'h1, RESP_OKAY);
    wrc(OFS_MODE, 32'h3, RESP_OKAY);
    rdc(OFS_MODE, 32'h1, RESP_OKAY);
    chk("user", 1'h0, user);
    rdp(4'hd, 1'b1, main_sp);
    for (k = 0; k < 8; k++) begin
      prim = k & 1;
      flt = (k >> 1) & 1;
      thr = (k > 3) ? rnd() % 512 : 0;
      wrc(OFS_EXC_MASK, prim, RESP_OKAY);
      wrc(OFS_FLTMASK_R, flt, RESP_OKAY);
      wrc(OFS_THRESH, thr, RESP_OKAY);
      rdc(OFS_THRESH, thr, RESP_OKAY);
      repeat (8) begin
        v = rnd();
        p = v[6] ? 9'(thr) : v[16:8];
        @(posedge clk);
        irq <= v[0] | v[1];
        nmi <= v[2] & v[3];
        hf <= v[4] & v[5];
        prio <= p;
        @(posedge clk);
        #1;
        x = (v[0] | v[1]) & ((v[2] & v[3]) | (!flt & ((v[4] & v[5]) |
            (!prim & (thr == 0 || p < thr)))));
        chk("irq_take", x, ok);
      end
    end
    crs_pipe_model_i.exc(1'b0, 9'h000);
  endtask

  // ==========================================================
  // main sequence with a second reset, and watchdog
  initial begin
    for (int pass = 0; pass < 2; pass++) begin
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      run_pass();
    end
    finish_test();
  end

  initial begin
    repeat (8000) @(posedge clk);
    num_errors++;
    finish_test();
  end
endmodule
